/* File: shared/wasc_pkg.sv */
// Purpose: constants and types of the auto-shutdown control block
// Assumes: 8-bit APB byte addresses, 32-bit data words
// Notes:   offsets, SDCS/CON0/IRQ field positions and register resets live here; status and pin resets are set in wasc_core
package wasc_pkg;

  // register byte offsets
  localparam logic [7:0] ADDR_SDCS  = 8'h00;
  localparam logic [7:0] ADDR_CON0  = 8'h04;
  localparam logic [7:0] ADDR_POL   = 8'h08;
  localparam logic [7:0] ADDR_DBAND = 8'h0C;
  localparam logic [7:0] ADDR_ISTAT = 8'h10;
  localparam logic [7:0] ADDR_IMASK = 8'h14;

  // shutdown_control_status, CON0 enable and interrupt bit positions
  localparam int SD_STATUS_BIT = 7;
  localparam int SD_RESUME_BIT = 6;
  localparam int SD_BD_LSB     = 4;
  localparam int SD_AC_LSB     = 2;
  localparam int CON0_EN_BIT   = 7;
  localparam int IRQ_ENTER_BIT = 0;
  localparam int IRQ_EXIT_BIT  = 1;

  // safe-state encodings
  localparam logic [1:0] SAFE_INACTIVE = 2'h0;
  localparam logic [1:0] SAFE_TRI      = 2'h1;
  localparam logic [1:0] SAFE_LOW      = 2'h2;
  localparam logic [1:0] SAFE_HIGH     = 2'h3;

  // reset values and dead-band width
  localparam logic [5:0] RST_SDCS  = 6'h00;
  localparam logic       RST_EN    = 1'h0;
  localparam logic [3:0] RST_POL   = 4'h0;
  localparam int         DBAND_W   = 6;
  localparam logic [5:0] RST_DBAND = 6'h00;
  localparam logic [1:0] RST_IRQ   = 2'h0;

  typedef enum logic [1:0] {
    WASC_RUN,
    WASC_SHUT,
    WASC_WAIT
  } wasc_state_t;

  typedef struct packed {
    logic a;
    logic b;
    logic c;
    logic d;
  } wasc_quad_t;

  typedef struct packed {
    wasc_quad_t level;
    wasc_quad_t oe_n;
  } wasc_pins_t;

endpackage

/* File: logic/wasc_core.sv */
// Purpose: auto-shutdown control and status of a four-output waveform generator
// Assumes: wave_in and period_start come from generator logic on pclk
// Notes:   shutdown_event is a pin and is synchronised before use
//
// The address map and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

// Contract
// - bit 7 reads one while the status flag is set; it clears before the pins release
// - bit 6 enables automatic restart
// - bits 5-4 pick B/D shutdown level
// - bits 3-2 pick A/C shutdown level
// - code 00 gives inactive level after dead-band
// - bits 1-0 read zero, writes ignored
// - status writable while generator disabled forces shutdown
module wasc_core (
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 ce,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [7:0]           paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire wasc_pkg::wasc_quad_t wave_in,
  input  wire logic                 period_start,
  input  wire logic                 shutdown_event,
  output wasc_pkg::wasc_pins_t      wave_pins,
  output logic                      shutdown_active,
  output logic                      generator_enable,
  output logic                      irq
);

  // pair drive: {oe_n[1:0], level[1:0]} for one output pair
  function automatic logic [3:0] pair_drive(
    input logic [1:0] sel,
    input logic [1:0] wave,
    input logic [1:0] pol,
    input logic       shut,
    input logic       db_done,
    input logic       en
  );
    logic [3:0] r;
    r = {2'h0, wave ^ pol};
    if (!shut) begin
      if (!en) begin
        r = {2'h0, pol};
      end
    end else begin
      unique case (sel)
        wasc_pkg::SAFE_HIGH:     r = {2'h0, 2'h3};
        wasc_pkg::SAFE_LOW:      r = {2'h0, 2'h0};
        wasc_pkg::SAFE_TRI:      r = {2'h3, 2'h0};
        wasc_pkg::SAFE_INACTIVE: r = db_done ? {2'h0, pol} : {2'h0, wave ^ pol};
      endcase
    end
    return r;
  endfunction

  // synchroniser for the event pin
  logic ev_meta_reg;
  logic ev_sync_reg;

  // software-visible state
  logic                        status_reg;
  logic                        status_next;
  logic                        resume_reg;
  logic [1:0]                  bd_sel_reg;
  logic [1:0]                  ac_sel_reg;
  logic                        en_reg;
  wasc_pkg::wasc_quad_t        pol_reg;
  logic [wasc_pkg::DBAND_W-1:0] dband_reg;
  logic [1:0]                  istat_reg;
  logic [1:0]                  istat_next;
  logic [1:0]                  imask_reg;

  // shutdown sequencing
  wasc_pkg::wasc_state_t        state_reg;
  wasc_pkg::wasc_state_t        state_next;
  logic [wasc_pkg::DBAND_W-1:0] db_cnt_reg;
  logic                         db_done_reg;
  wasc_pkg::wasc_pins_t         pins_reg;

  // bus side
  logic        rd_ok_reg;
  logic [31:0] prdata_reg;

  // decode
  wire acc       = psel & penable;
  wire wr_fire   = acc & pwrite & pready;
  wire hit_sdcs  = (paddr == wasc_pkg::ADDR_SDCS);
  wire hit_con0  = (paddr == wasc_pkg::ADDR_CON0);
  wire hit_pol   = (paddr == wasc_pkg::ADDR_POL);
  wire hit_dband = (paddr == wasc_pkg::ADDR_DBAND);
  wire hit_istat = (paddr == wasc_pkg::ADDR_ISTAT);
  wire hit_imask = (paddr == wasc_pkg::ADDR_IMASK);
  wire hit_any   = hit_sdcs | hit_con0 | hit_pol | hit_dband | hit_istat | hit_imask;
  wire wr_sdcs   = wr_fire & hit_sdcs;
  wire wr_con0   = wr_fire & hit_con0;
  wire wr_pol    = wr_fire & hit_pol;
  wire wr_dband  = wr_fire & hit_dband;
  wire wr_istat  = wr_fire & hit_istat;
  wire wr_imask  = wr_fire & hit_imask;

  // status flag causes
  wire hw_set   = ev_sync_reg & en_reg;
  wire sw_set   = wr_sdcs & pwdata[wasc_pkg::SD_STATUS_BIT] & ~en_reg;
  wire sw_clr   = wr_sdcs & ~pwdata[wasc_pkg::SD_STATUS_BIT];
  wire auto_clr = resume_reg & en_reg & ~ev_sync_reg;

  // a set in the same cycle as any clear wins
  assign status_next = hw_set | sw_set | (status_reg & ~sw_clr & ~auto_clr);

  // state sequencing; release on a period boundary or when the generator is disabled
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      wasc_pkg::WASC_RUN: begin
        if (status_reg) begin
          state_next = wasc_pkg::WASC_SHUT;
        end
      end
      wasc_pkg::WASC_SHUT: begin
        if (!status_reg) begin
          state_next = wasc_pkg::WASC_WAIT;
        end
      end
      wasc_pkg::WASC_WAIT: begin
        if (status_reg) begin
          state_next = wasc_pkg::WASC_SHUT;
        end else if (period_start | ~en_reg) begin
          state_next = wasc_pkg::WASC_RUN;
        end
      end
      default: state_next = wasc_pkg::WASC_RUN;
    endcase
  end

  wire shut_now  = (state_reg != wasc_pkg::WASC_RUN);
  wire entering  = (state_reg == wasc_pkg::WASC_RUN) & status_reg;
  wire leaving   = (state_reg == wasc_pkg::WASC_WAIT) & (state_next == wasc_pkg::WASC_RUN);

  // interrupt events, sticky until written with one
  wire [1:0] irq_evt = {leaving, entering};
  wire [1:0] irq_clr = wr_istat ? pwdata[1:0] : 2'h0;
  assign istat_next = irq_evt | (istat_reg & ~irq_clr);

  // pair drive selection
  wire [3:0] drv_ac = pair_drive(ac_sel_reg, {wave_in.a, wave_in.c}, {pol_reg.a, pol_reg.c},
                                 shut_now, db_done_reg, en_reg);
  wire [3:0] drv_bd = pair_drive(bd_sel_reg, {wave_in.b, wave_in.d}, {pol_reg.b, pol_reg.d},
                                 shut_now, db_done_reg, en_reg);

  wasc_pkg::wasc_pins_t pins_next;
  assign pins_next.level.a = drv_ac[1];
  assign pins_next.level.c = drv_ac[0];
  assign pins_next.oe_n.a  = drv_ac[3];
  assign pins_next.oe_n.c  = drv_ac[2];
  assign pins_next.level.b = drv_bd[1];
  assign pins_next.level.d = drv_bd[0];
  assign pins_next.oe_n.b  = drv_bd[3];
  assign pins_next.oe_n.d  = drv_bd[2];

  // read mux; unimplemented low bits read zero
  wire [7:0] sdcs_view = {status_reg, resume_reg, bd_sel_reg, ac_sel_reg, 2'h0};
  wire [31:0] rd_mux =
      hit_sdcs  ? {24'h000000, sdcs_view} :
      hit_con0  ? {24'h000000, en_reg, 7'h00} :
      hit_pol   ? {28'h0000000, pol_reg} :
      hit_dband ? {26'h0000000, dband_reg} :
      hit_istat ? {30'h00000000, istat_reg} :
      hit_imask ? {30'h00000000, imask_reg} : 32'h00000000;

  // read data is captured in the setup cycle so it comes from a flop
  wire rd_req  = psel & ~pwrite;
  wire rd_cap  = rd_req & ~rd_ok_reg & ce;
  wire rd_done = acc & ~pwrite & pready;

  assign pready  = ce & (pwrite | rd_ok_reg);
  assign pslverr = acc & pready & ~hit_any;
  assign prdata  = prdata_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ev_meta_reg <= 1'b0;
      ev_sync_reg <= 1'b0;
    end else if (ce) begin
      ev_meta_reg <= shutdown_event;
      ev_sync_reg <= ev_meta_reg;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_reg <= 1'b0;
    end else if (ce) begin
      status_reg <= status_next;
    end
  end

  // writes to bits 1-0 are dropped here
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {resume_reg, bd_sel_reg, ac_sel_reg} <= wasc_pkg::RST_SDCS[4:0];
    end else if (wr_sdcs) begin
      resume_reg <= pwdata[wasc_pkg::SD_RESUME_BIT];
      bd_sel_reg <= pwdata[wasc_pkg::SD_BD_LSB +: 2];
      ac_sel_reg <= pwdata[wasc_pkg::SD_AC_LSB +: 2];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_reg <= wasc_pkg::RST_EN;
    end else if (wr_con0) begin
      en_reg <= pwdata[wasc_pkg::CON0_EN_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pol_reg <= wasc_pkg::RST_POL;
    end else if (wr_pol) begin
      pol_reg <= pwdata[3:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dband_reg <= wasc_pkg::RST_DBAND;
    end else if (wr_dband) begin
      dband_reg <= pwdata[wasc_pkg::DBAND_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      istat_reg <= wasc_pkg::RST_IRQ;
      imask_reg <= wasc_pkg::RST_IRQ;
    end else if (ce) begin
      istat_reg <= istat_next;
      if (wr_imask) begin
        imask_reg <= pwdata[1:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= wasc_pkg::WASC_RUN;
    end else if (ce) begin
      state_reg <= state_next;
    end
  end

  // dead-band count restarts on entry into shutdown from WASC_RUN; a return from WASC_WAIT keeps it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      db_cnt_reg  <= wasc_pkg::RST_DBAND;
      db_done_reg <= 1'b0;
    end else if (ce) begin
      if (entering) begin
        db_cnt_reg  <= dband_reg;
        db_done_reg <= 1'b0;
      end else if (!shut_now) begin
        db_done_reg <= 1'b0;
      end else if (db_cnt_reg != '0) begin
        db_cnt_reg <= db_cnt_reg - 1'b1;
      end else begin
        db_done_reg <= 1'b1;
      end
    end
  end

  // pins from flops: no glitch reaches the power stage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pins_reg.level <= wasc_pkg::RST_POL;
      pins_reg.oe_n  <= 4'hF;
    end else if (ce) begin
      pins_reg <= pins_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_ok_reg  <= 1'b0;
      prdata_reg <= 32'h00000000;
    end else if (ce) begin
      rd_ok_reg <= rd_req & ~rd_done & (rd_ok_reg | rd_cap);
      if (rd_cap) begin
        prdata_reg <= rd_mux;
      end
    end
  end

  assign wave_pins        = pins_reg;
  assign shutdown_active  = shut_now;
  assign generator_enable = en_reg;
  assign irq              = |(istat_reg & imask_reg);

endmodule

`default_nettype wire

/* File: test/wasc_chk.sv */
// Purpose: port checker for wasc_core
// Assumes: aligned addresses only
// Notes:   safe-state fields are tracked from bus writes
`timescale 1ns/1ps
`default_nettype none
module wasc_chk (
  input wire logic                 pclk,
  input wire logic                 presetn,
  input wire logic                 ce,
  input wire logic                 psel,
  input wire logic                 penable,
  input wire logic                 pwrite,
  input wire logic [7:0]           paddr,
  input wire logic [31:0]          pwdata,
  input wire logic [31:0]          prdata,
  input wire logic                 pready,
  input wire logic                 pslverr,
  input wire logic                 period_start,
  input wire logic                 shutdown_event,
  input wire wasc_pkg::wasc_pins_t wave_pins,
  input wire logic                 shutdown_active,
  input wire logic                 generator_enable
);
  logic [3:0] cfg_reg;
  wire        done = psel && penable && pready;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      cfg_reg <= 4'h0;
    else if (done && pwrite && paddr == wasc_pkg::ADDR_SDCS)
      cfg_reg <= pwdata[5:2];
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // pins may lag a field change by one edge
  sequence s_held;
    (shutdown_active && $stable(cfg_reg))[*3];
  endsequence
  a_forced_bd: assert property (s_held ##0 cfg_reg[3] |-> wave_pins.level.b == cfg_reg[2] &&
    wave_pins.level.d == cfg_reg[2] && !wave_pins.oe_n.b && !wave_pins.oe_n.d) else $error("bd level");
  a_forced_ac: assert property (s_held ##0 cfg_reg[1] |-> wave_pins.level.a == cfg_reg[0] &&
    wave_pins.level.c == cfg_reg[0] && !wave_pins.oe_n.a && !wave_pins.oe_n.c) else $error("ac level");
  a_tri_bd: assert property (s_held ##0 cfg_reg[3:2] == 2'h1 |-> wave_pins.oe_n.b && wave_pins.oe_n.d)
    else $error("bd not released");
  a_tri_ac: assert property (s_held ##0 cfg_reg[1:0] == 2'h1 |-> wave_pins.oe_n.a && wave_pins.oe_n.c)
    else $error("ac not released");
  a_enter_shut: assert property ((ce && generator_enable && shutdown_event)[*5] |=> shutdown_active)
    else $error("no shutdown");
  a_resume_edge: assert property ($fell(shutdown_active) |-> $past(period_start) || !$past(generator_enable))
    else $error("resume off boundary");
  a_bits_zero: assert property (done && !pwrite && paddr == wasc_pkg::ADDR_SDCS |->
    prdata[1:0] == 2'h0 && prdata[31:8] == 24'h000000) else $error("unused bits set");
  a_bus_err: assert property (done |-> pslverr == (paddr > wasc_pkg::ADDR_IMASK)) else $error("slverr");
  a_write_ready: assert property (psel && penable && pwrite && ce |-> pready) else $error("write wait");
endmodule
bind wasc_core wasc_chk i_wasc_chk (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata,
  .prdata, .pready, .pslverr, .period_start, .shutdown_event, .wave_pins, .shutdown_active, .generator_enable);
`default_nettype wire

/* File: test/wasc_stage.sv */
// Purpose: power stage seen by the four wave pins
// Assumes: no pull on the pins
// Notes:   a released pin wanders so it never shows a stale level
`timescale 1ns/1ps
`default_nettype none
module wasc_stage (
  input wire logic                 pclk,
  input wire wasc_pkg::wasc_pins_t wave_pins,
  output logic [3:0]               wire_lvl
);
  logic [3:0] float_reg;
  always_ff @(posedge pclk)
    float_reg <= (float_reg === 4'h5) ? 4'hA : 4'h5;
  assign wire_lvl = (wave_pins.level & ~wave_pins.oe_n) | (float_reg & wave_pins.oe_n);
endmodule
`default_nettype wire

/* File: test/testbench.sv */
// Purpose: self-checking bench for wasc_core
// Assumes: ce held high
// Notes:   random fields and waves from a fixed seed
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic pclk = 0, presetn = 0, ce = 1, psel = 0, penable = 0, pwrite = 0;
  logic period_start = 0, shutdown_event = 0, pready, pslverr, shutdown_active, generator_enable, irq, err;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q, d, seed = 32'h14;
  logic [3:0] wire_lvl;
  wasc_pkg::wasc_quad_t wave_in = 4'h0;
  wasc_pkg::wasc_pins_t wave_pins;
  int fails = 0, cmp_count = 0, cyc = 0, n;
  always #2 pclk = ~pclk;
  wasc_core i_wasc_core (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .wave_in, .period_start, .shutdown_event, .wave_pins, .shutdown_active, .generator_enable, .irq);
  wasc_stage i_wasc_stage (.pclk, .wave_pins, .wire_lvl);
  function logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task complete_run();
    if (fails == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // request held until pready is sampled high at a rising edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] v);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= v;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wt(input logic v);
    n = 0;
    @(negedge pclk);
    while (shutdown_active !== v && n < 40) begin
      @(negedge pclk);
      n++;
    end
    chk(32'(shutdown_active), 32'(v));
  endtask
  task pulse();
    @(posedge pclk);
    period_start <= 1'b1;
    @(posedge pclk);
    period_start <= 1'b0;
  endtask
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      fails++;
      complete_run();
    end
  end
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 7; i++) begin
      apb(1'b0, 8'(4 * i), 32'h0);
      chk(q, 32'h0);
      chk(32'(err), 32'(i == 6));
    end
    repeat (4) begin
      d = xs() & 32'hFFFF_FF7F;
      apb(1'b1, wasc_pkg::ADDR_SDCS, d);
      apb(1'b0, wasc_pkg::ADDR_SDCS, 32'h0);
      chk(q, d & 32'h0000_007C);
    end
    wave_in <= 4'(xs());
    apb(1'b1, wasc_pkg::ADDR_SDCS, 32'h0000_00B8);
    wt(1'b1);
    repeat (3) @(negedge pclk);
    chk(32'(wire_lvl), 32'h5);
    chk(32'(wave_pins.oe_n), 32'h0);
    apb(1'b0, wasc_pkg::ADDR_SDCS, 32'h0);
    chk(q, 32'h0000_00B8);
    apb(1'b1, wasc_pkg::ADDR_SDCS, 32'h0000_0038);
    wt(1'b0);
    @(posedge pclk);
    wave_in <= 4'hF;
    apb(1'b1, wasc_pkg::ADDR_POL, 32'h5);
    apb(1'b1, wasc_pkg::ADDR_DBAND, 32'h3);
    apb(1'b1, wasc_pkg::ADDR_CON0, 32'h80);
    apb(1'b1, wasc_pkg::ADDR_SDCS, 32'h44);
    shutdown_event <= 1'b1;
    wt(1'b1);
    apb(1'b0, wasc_pkg::ADDR_SDCS, 32'h0);
    chk(q, 32'h0000_00C4);
    repeat (4) @(negedge pclk);
    chk(32'(wave_pins.oe_n & 4'hA), 32'hA);
    chk(32'(wire_lvl & 4'h5), 32'h5);
    @(posedge pclk);
    shutdown_event <= 1'b0;
    repeat (12) @(negedge pclk);
    chk(32'(shutdown_active), 32'h1);
    apb(1'b0, wasc_pkg::ADDR_SDCS, 32'h0);
    chk(q, 32'h44);
    pulse();
    wt(1'b0);
    @(negedge pclk);
    chk(32'(wire_lvl), 32'hA);
    chk(32'(irq), 32'h0);
    apb(1'b0, wasc_pkg::ADDR_ISTAT, 32'h0);
    chk(q, 32'h3);
    apb(1'b1, wasc_pkg::ADDR_IMASK, 32'h1);
    @(negedge pclk);
    chk(32'(irq), 32'h1);
    apb(1'b1, wasc_pkg::ADDR_ISTAT, 32'h1);
    apb(1'b0, wasc_pkg::ADDR_ISTAT, 32'h0);
    chk(q, 32'h2);
    chk(32'(irq), 32'h0);
    apb(1'b1, wasc_pkg::ADDR_SDCS, 32'h30);
    shutdown_event <= 1'b1;
    wt(1'b1);
    @(posedge pclk);
    shutdown_event <= 1'b0;
    repeat (12) @(negedge pclk);
    pulse();
    apb(1'b0, wasc_pkg::ADDR_SDCS, 32'h0);
    chk(q, 32'h0000_00B0);
    chk(32'(shutdown_active), 32'h1);
    apb(1'b1, wasc_pkg::ADDR_SDCS, 32'h30);
    pulse();
    wt(1'b0);
    complete_run();
  end
endmodule
`default_nettype wire
